// *** rtl/adcr_pkg.sv ***
// Package: register map, field positions and types of the converter
// control block.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
`default_nettype none
package adcr_pkg;
    // -----------------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] OFF_PIN_EN = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_OFFCAL = 8'h08;
    localparam logic [7:0] OFF_RES_UP = 8'h0C;
    localparam logic [7:0] OFF_RES_HN = 8'h10;
    localparam logic [7:0] OFF_RES_LO = 8'h14;
    localparam logic [7:0] OFF_INT_ST = 8'h18;
    localparam logic [7:0] OFF_INT_MSK = 8'h1C;
    localparam logic [7:0] OFF_TMR_CTL = 8'h20;
    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int CTRL_REF_SEL = 7;
    localparam int CTRL_CKR_LO = 5;
    localparam int CTRL_RUN = 4;
    localparam int CTRL_PWR = 3;
    localparam int CTRL_CH_LO = 0;
    localparam int OC_ENABLE = 7;
    localparam int OC_SIGN = 6;
    localparam int OC_MAG_LO = 3;
    localparam int IS_DONE = 5;
    localparam int IS_WAKE = 3;
    localparam int TC_SRC = 5;
    // -----------------------------------------------------------------
    // Reset values and masks
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_PIN_EN = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_OFFCAL = 8'h00;
    localparam logic [7:0] RST_INT_MSK = 8'h00;
    localparam logic [7:0] RST_TMR_CTL = 8'h00;
    localparam logic [7:0] MASK_PIN_EN = 8'h0F;
    localparam logic [7:0] MASK_OFFCAL = 8'hF8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // -----------------------------------------------------------------
    // Clock rate codes
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCR_DIV16 = 2'h0,
        ADCR_DIV4 = 2'h1,
        ADCR_DIV64 = 2'h2,
        ADCR_RING = 2'h3
    } adcr_ckr_t;
    localparam logic [5:0] DIV16_LAST = 6'h0F;
    localparam logic [5:0] DIV4_LAST = 6'h03;
    localparam logic [5:0] DIV64_LAST = 6'h3F;
    // -----------------------------------------------------------------
    // Carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic power_on;
        logic ref_ext;
        logic [1:0] channel;
        logic cal_en;
        logic cal_pos;
        logic [4:0] cal_lsb;
    } adcr_conv_cmd_t;
    typedef struct packed {
        logic done;
        logic [11:0] result;
    } adcr_conv_res_t;
endpackage
`default_nettype wire

// *** rtl/adcr_axil.sv ***
// AXI4-Lite slave front end: takes one write and one read at a time and
// presents them to the register file as single-cycle strobes.
// Assumes the register file answers reads combinationally.
`default_nettype none
module adcr_axil (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_wr_stb,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    input wire logic i_wr_ok,
    output logic o_rd_stb,
    output logic [7:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_ok
);
    logic aw_have_reg, w_have_reg;
    logic [7:0] awaddr_reg, wdata_reg;

    // -----------------------------------------------------------------
    // Write path
    // -----------------------------------------------------------------
    assign o_awready = !aw_have_reg && !o_bvalid;
    assign o_wready = !w_have_reg && !o_bvalid;
    assign o_wr_stb = aw_have_reg && w_have_reg && !o_bvalid;
    assign o_wr_addr = awaddr_reg;
    assign o_wr_data = wdata_reg;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            o_bvalid <= 1'b0;
            o_bresp <= 2'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_reg <= 1'b1;
                // Only the low byte lane carries register data.
                wdata_reg <= i_wstrb[0] ? i_wdata[7:0] : 8'h00;
            end
            if (o_wr_stb) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= i_wr_ok ? adcr_pkg::RESP_OKAY
                                   : adcr_pkg::RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------
    assign o_arready = !o_rvalid;
    assign o_rd_stb = i_arvalid && o_arready;
    assign o_rd_addr = i_araddr;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'h0;
        end else if (o_rd_stb) begin
            o_rvalid <= 1'b1;
            o_rdata <= {24'h00_0000, i_rd_data};
            o_rresp <= i_rd_ok ? adcr_pkg::RESP_OKAY
                               : adcr_pkg::RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** rtl/adcr_clkdiv.sv ***
// Conversion clock divider: a one-cycle tick every 4, 16 or 64 system
// clocks, or a synchronised edge of the ring oscillator.
// Assumes the ring oscillator input is asynchronous to the system clock.
`default_nettype none
module adcr_clkdiv (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_run,
    input wire adcr_pkg::adcr_ckr_t i_rate,
    input wire logic i_ring_osc,
    output logic o_tick
);
    logic [5:0] cnt_reg;
    logic [5:0] last;
    logic [2:0] ring_sync_reg;
    logic ring_tick;

    always_comb begin
        case (i_rate)
            adcr_pkg::ADCR_DIV4: last = adcr_pkg::DIV4_LAST;
            adcr_pkg::ADCR_DIV64: last = adcr_pkg::DIV64_LAST;
            default: last = adcr_pkg::DIV16_LAST;
        endcase
    end

    // Rising edge counts while the second stage is high and the third is still low.
    assign ring_tick = ring_sync_reg[1] && !ring_sync_reg[2];

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ring_sync_reg <= 3'h0;
        end else begin
            ring_sync_reg <= {ring_sync_reg[1:0], i_ring_osc};
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_reg <= 6'h00;
        end else if (!i_run || cnt_reg >= last) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    always_comb begin
        if (!i_run) begin
            o_tick = 1'b0;
        end else if (i_rate == adcr_pkg::ADCR_RING) begin
            o_tick = ring_tick;
        end else begin
            o_tick = (cnt_reg >= last);
        end
    end
endmodule
`default_nettype wire

// *** rtl/adcr_top.sv ***
// Converter control register block: pin mode, reference, clock rate,
// start/run, power, channel, offset calibration and result registers.
// Assumes an AXI4-Lite master and an analog core that pulses done.
// Function
// - Enable bits make port pins analog inputs.
// - Reference bit selects supply or shared pin.
// - Shared pin priority reference, timer, port.
// - Clock field divides by 16, 4, 64, ring.
// - Run bit set by software, cleared by hardware.
// - Power bit low switches reference off.
// - Channel field routes pin 0 to 3.
// - Channel changes only when done and run low.
// - Calibration bit enables offset calibration.
// - Sign bit chooses offset polarity.
// - Magnitude gives two LSB per code step.
// - Low three calibration bits read zero.
// - Upper result byte loads, ignores writes.
// - High nibble register loads bits 11 to 8.
// - Completion clears run and sets done flag.
// - Low result byte loads result bits 7-0.
// - Done flag hardware set, software cleared, masked read.
// - Wake enable lets completion wake processor.
// - Shared pin is timer clock when source bit set.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`default_nettype none
module adcr_top (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic I_RING_OSC,
    input wire logic I_SLEEPING,
    input wire adcr_pkg::adcr_conv_res_t I_CONV_RES,
    output adcr_pkg::adcr_conv_cmd_t O_CONV_CMD,
    output logic O_CONV_TICK,
    output logic [3:0] O_ANALOG_PIN,
    output logic O_REF_PIN_ANALOG,
    output logic O_REF_PIN_TIMER,
    output logic O_REF_PIN_PORT,
    output logic O_WAKE
);
    logic wr_stb, rd_stb, wr_ok, rd_ok;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    logic [7:0] pin_en_reg, offcal_reg, int_msk_reg, tmr_ctl_reg;
    logic ref_sel_reg, run_reg, pwr_reg, done_reg, wake_en_reg;
    logic [1:0] ckr_reg, chan_reg;
    logic [7:0] res_up_reg, res_hn_reg, res_lo_reg;
    logic conv_done, start_req;
    logic wr_ctrl, wr_int;

    // -----------------------------------------------------------------
    // Bus front end and clock divider
    // -----------------------------------------------------------------
    adcr_axil u_axil (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_awaddr(I_AWADDR),
        .i_awvalid(I_AWVALID),
        .o_awready(O_AWREADY),
        .i_wdata(I_WDATA),
        .i_wstrb(I_WSTRB),
        .i_wvalid(I_WVALID),
        .o_wready(O_WREADY),
        .o_bresp(O_BRESP),
        .o_bvalid(O_BVALID),
        .i_bready(I_BREADY),
        .i_araddr(I_ARADDR),
        .i_arvalid(I_ARVALID),
        .o_arready(O_ARREADY),
        .o_rdata(O_RDATA),
        .o_rresp(O_RRESP),
        .o_rvalid(O_RVALID),
        .i_rready(I_RREADY),
        .o_wr_stb(wr_stb),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .i_wr_ok(wr_ok),
        .o_rd_stb(rd_stb),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .i_rd_ok(rd_ok)
    );

    adcr_clkdiv u_clkdiv (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_run(run_reg && pwr_reg),
        .i_rate(adcr_pkg::adcr_ckr_t'(ckr_reg)),
        .i_ring_osc(I_RING_OSC),
        .o_tick(O_CONV_TICK)
    );

    // -----------------------------------------------------------------
    // Write decode
    // -----------------------------------------------------------------
    assign wr_ctrl = wr_stb && wr_addr == adcr_pkg::OFF_CTRL;
    assign wr_int = wr_stb && wr_addr == adcr_pkg::OFF_INT_ST;
    // Completion is only honoured while a conversion is running.
    assign conv_done = I_CONV_RES.done && run_reg;
    assign start_req = wr_ctrl && wr_data[adcr_pkg::CTRL_RUN] && !run_reg;

    always_comb begin
        case (wr_addr)
            adcr_pkg::OFF_PIN_EN, adcr_pkg::OFF_CTRL,
            adcr_pkg::OFF_OFFCAL, adcr_pkg::OFF_RES_UP,
            adcr_pkg::OFF_RES_HN, adcr_pkg::OFF_RES_LO,
            adcr_pkg::OFF_INT_ST, adcr_pkg::OFF_INT_MSK,
            adcr_pkg::OFF_TMR_CTL: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // Plain configuration registers
    // -----------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            pin_en_reg <= adcr_pkg::RST_PIN_EN;
            offcal_reg <= adcr_pkg::RST_OFFCAL;
            int_msk_reg <= adcr_pkg::RST_INT_MSK;
            tmr_ctl_reg <= adcr_pkg::RST_TMR_CTL;
        end else if (wr_stb) begin
            case (wr_addr)
                adcr_pkg::OFF_PIN_EN:
                    pin_en_reg <= wr_data & adcr_pkg::MASK_PIN_EN;
                adcr_pkg::OFF_OFFCAL:
                    offcal_reg <= wr_data & adcr_pkg::MASK_OFFCAL;
                adcr_pkg::OFF_INT_MSK: int_msk_reg <= wr_data;
                adcr_pkg::OFF_TMR_CTL: tmr_ctl_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Control register
    // -----------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ref_sel_reg <= adcr_pkg::RST_CTRL[adcr_pkg::CTRL_REF_SEL];
            ckr_reg <= adcr_pkg::RST_CTRL[adcr_pkg::CTRL_CKR_LO +: 2];
            pwr_reg <= adcr_pkg::RST_CTRL[adcr_pkg::CTRL_PWR];
            chan_reg <= adcr_pkg::RST_CTRL[adcr_pkg::CTRL_CH_LO +: 2];
        end else if (wr_ctrl) begin
            ref_sel_reg <= wr_data[adcr_pkg::CTRL_REF_SEL];
            ckr_reg <= wr_data[adcr_pkg::CTRL_CKR_LO +: 2];
            pwr_reg <= wr_data[adcr_pkg::CTRL_PWR];
            if (!done_reg && !run_reg && !start_req) begin
                chan_reg <= wr_data[adcr_pkg::CTRL_CH_LO +: 2];
            end else if (!done_reg && !run_reg) begin
                // Channel written together with the start takes effect.
                chan_reg <= wr_data[adcr_pkg::CTRL_CH_LO +: 2];
            end
        end
    end

    // Software start wins over the completion clear; software never clears.
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            run_reg <= adcr_pkg::RST_CTRL[adcr_pkg::CTRL_RUN];
        end else if (start_req) begin
            run_reg <= 1'b1;
        end else if (conv_done) begin
            run_reg <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Completion flag and wake enable
    // -----------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            done_reg <= 1'b0;
            wake_en_reg <= 1'b0;
        end else begin
            if (conv_done) begin
                done_reg <= 1'b1;
            end else if (wr_int && !wr_data[adcr_pkg::IS_DONE]) begin
                done_reg <= 1'b0;
            end
            if (wr_int) begin
                wake_en_reg <= wr_data[adcr_pkg::IS_WAKE];
            end
        end
    end

    // -----------------------------------------------------------------
    // Result registers
    // -----------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            res_up_reg <= 8'h00;
            res_hn_reg <= 8'h00;
            res_lo_reg <= 8'h00;
        end else if (conv_done) begin
            res_up_reg <= I_CONV_RES.result[11:4];
            res_hn_reg <= {4'h0, I_CONV_RES.result[11:8]};
            res_lo_reg <= I_CONV_RES.result[7:0];
        end
    end

    // -----------------------------------------------------------------
    // Read mux
    // -----------------------------------------------------------------
    always_comb begin
        rd_ok = 1'b1;
        case (rd_addr)
            adcr_pkg::OFF_PIN_EN: rd_data = pin_en_reg;
            adcr_pkg::OFF_CTRL: rd_data = {ref_sel_reg, ckr_reg, run_reg,
                                           pwr_reg, 1'b0, chan_reg};
            adcr_pkg::OFF_OFFCAL: rd_data = offcal_reg;
            adcr_pkg::OFF_RES_UP: rd_data = res_up_reg;
            adcr_pkg::OFF_RES_HN: rd_data = res_hn_reg;
            adcr_pkg::OFF_RES_LO: rd_data = res_lo_reg;
            adcr_pkg::OFF_INT_ST: rd_data = {2'h0,
                done_reg & int_msk_reg[adcr_pkg::IS_DONE], 1'b0,
                wake_en_reg, 3'h0};
            adcr_pkg::OFF_INT_MSK: rd_data = int_msk_reg;
            adcr_pkg::OFF_TMR_CTL: rd_data = tmr_ctl_reg;
            default: begin
                rd_data = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Converter command and pin functions
    // -----------------------------------------------------------------
    always_comb begin
        O_CONV_CMD.start = run_reg;
        O_CONV_CMD.power_on = pwr_reg;
        O_CONV_CMD.ref_ext = ref_sel_reg;
        O_CONV_CMD.channel = chan_reg;
        O_CONV_CMD.cal_en = offcal_reg[adcr_pkg::OC_ENABLE];
        O_CONV_CMD.cal_pos = offcal_reg[adcr_pkg::OC_SIGN];
        O_CONV_CMD.cal_lsb = {1'b0, offcal_reg[adcr_pkg::OC_MAG_LO +: 3],
                              1'b0};
    end

    assign O_ANALOG_PIN = pin_en_reg[3:0];
    assign O_REF_PIN_ANALOG = ref_sel_reg;
    assign O_REF_PIN_TIMER = !ref_sel_reg &&
                             tmr_ctl_reg[adcr_pkg::TC_SRC];
    assign O_REF_PIN_PORT = !O_REF_PIN_ANALOG && !O_REF_PIN_TIMER;
    assign O_WAKE = I_SLEEPING && wake_en_reg && conv_done;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    run_clear_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        conv_done && !start_req |=> !run_reg && done_reg)
        else $error("run not cleared or flag not set at completion");
    run_hold_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        run_reg && !conv_done |=> run_reg)
        else $error("run bit dropped without completion");
    start_set_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        wr_ctrl && wr_data[adcr_pkg::CTRL_RUN] && !run_reg |=> run_reg)
        else $error("start write did not set run");
    chan_lock_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        (run_reg || done_reg) |=> $stable(chan_reg))
        else $error("channel changed while locked");
    result_load_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        conv_done |=> res_up_reg == $past(I_CONV_RES.result[11:4]) &&
        res_lo_reg == $past(I_CONV_RES.result[7:0]))
        else $error("result registers not loaded together");
    nibble_top_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        res_hn_reg[7:4] == 4'h0 && res_hn_reg[3:0] == res_up_reg[7:4])
        else $error("high nibble register inconsistent");
    result_stable_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        !conv_done |=> $stable(res_lo_reg) && $stable(res_up_reg))
        else $error("result changed without completion");
    flag_no_set_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        !done_reg && !conv_done |=> !done_reg)
        else $error("done flag set without completion");
    cal_low_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        offcal_reg[2:0] == 3'h0 && O_CONV_CMD.cal_lsb[0] == 1'b0)
        else $error("calibration low bits not zero");
    pin_prio_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
        $onehot({O_REF_PIN_ANALOG, O_REF_PIN_TIMER, O_REF_PIN_PORT}))
        else $error("shared pin function not unique");
    conv_c: cover property (@(posedge I_CLK) disable iff (I_RESET)
        start_req ##[1:200] conv_done);
    clear_c: cover property (@(posedge I_CLK) disable iff (I_RESET)
        done_reg ##1 !done_reg);
    busy_start_c: cover property (@(posedge I_CLK) disable iff (I_RESET)
        run_reg && wr_ctrl && wr_data[adcr_pkg::CTRL_RUN]);
endmodule
`default_nettype wire

// *** verif/adcr_core_model.sv ***
// Behavioural analog core: counts conversion ticks after a start and
// pulses done with a fixed result that carries the selected channel.
// Assumes the command and tick come from the control block.
`default_nettype none
module adcr_core_model #(
    parameter logic [11:0] RES_BASE = 12'hAB0
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire adcr_pkg::adcr_conv_cmd_t i_cmd,
    input wire logic i_tick,
    output adcr_pkg::adcr_conv_res_t o_res
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_reg;
    logic sent_reg;
    // Outside the done pulse the result bus keeps changing.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_res <= '0;
            cnt_reg <= 2'h0;
            sent_reg <= 1'b0;
        end else begin
            o_res.done <= 1'b0;
            o_res.result <= ~o_res.result;
            if (!i_cmd.start) begin
                cnt_reg <= 2'h0;
                sent_reg <= 1'b0;
            end else if (i_tick && !sent_reg) begin
                cnt_reg <= cnt_reg + 2'h1;
                if (cnt_reg == 2'h3) begin
                    o_res <= {1'b1, RES_BASE | {10'h0, i_cmd.channel}};
                    sent_reg <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/adcr_top_test.sv ***
// Testbench: register accesses over AXI4-Lite and two conversions.
// Assumes the design and the core model are compiled before it.
`default_nettype none
module adcr_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_CLK = 0, I_RESET = 1, I_AWVALID = 0, I_WVALID = 0;
    logic I_ARVALID = 0, I_BREADY = 1, I_RREADY = 1;
    logic I_RING_OSC = 0, I_SLEEPING = 0;
    logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
    logic [31:0] I_WDATA = 32'h0, O_RDATA, rdat;
    logic [3:0] I_WSTRB = 4'hF, O_ANALOG_PIN;
    logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_CONV_TICK;
    logic O_REF_PIN_ANALOG, O_REF_PIN_TIMER, O_REF_PIN_PORT, O_WAKE;
    logic [1:0] O_BRESP, O_RRESP, rresp, bresp;
    logic woke = 1'b0;
    adcr_pkg::adcr_conv_res_t I_CONV_RES;
    adcr_pkg::adcr_conv_cmd_t O_CONV_CMD;
    int failures = 0, n_tests = 0;
    adcr_top dut (.*);
    adcr_core_model core (.i_clk(I_CLK), .i_reset(I_RESET),
        .i_cmd(O_CONV_CMD), .i_tick(O_CONV_TICK), .o_res(I_CONV_RES));
    always #4 I_CLK = ~I_CLK;
    always #37 I_RING_OSC = ~I_RING_OSC;
    // Remembers any wake pulse, which stands for one cycle only.
    always @(posedge I_CLK) begin
        if (O_WAKE) woke <= 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ready and valid are read as they stood at the rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_CLK);
        I_AWADDR <= a;
        I_WDATA <= {24'h0, d};
        I_AWVALID <= 1'b1;
        I_WVALID <= 1'b1;
        do begin
            @(posedge I_CLK);
            if (O_AWREADY) I_AWVALID <= 1'b0;
            if (O_WREADY) I_WVALID <= 1'b0;
        end while (!O_BVALID);
        bresp = O_BRESP;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge I_CLK);
        I_ARADDR <= a;
        I_ARVALID <= 1'b1;
        do begin
            @(posedge I_CLK);
            if (O_ARREADY) I_ARVALID <= 1'b0;
        end while (!O_RVALID);
        rdat = O_RDATA;
        rresp = O_RRESP;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk(rdat, {24'h0, exp});
    endtask
    task automatic wait_idle;
        repeat (40) begin
            rd(adcr_pkg::OFF_CTRL);
            if (rdat[4] === 1'b0) break;
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge I_CLK);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge I_CLK);
        I_RESET <= 1'b0;
        rc(adcr_pkg::OFF_CTRL, 8'h00);
        wr(adcr_pkg::OFF_PIN_EN, 8'hFF);
        rc(adcr_pkg::OFF_PIN_EN, 8'h0F);
        chk(O_ANALOG_PIN, 4'hF);
        wr(adcr_pkg::OFF_OFFCAL, 8'hFF);
        rc(adcr_pkg::OFF_OFFCAL, 8'hF8);
        chk(O_CONV_CMD[6:0], 7'h6E);
        chk({O_REF_PIN_ANALOG, O_REF_PIN_TIMER, O_REF_PIN_PORT}, 1);
        wr(adcr_pkg::OFF_TMR_CTL, 8'h20);
        chk({O_REF_PIN_ANALOG, O_REF_PIN_TIMER, O_REF_PIN_PORT}, 2);
        wr(adcr_pkg::OFF_CTRL, 8'h80);
        chk({O_REF_PIN_ANALOG, O_REF_PIN_TIMER, O_REF_PIN_PORT}, 4);
        chk(O_CONV_CMD[11:9], 3'h1);
        $display("test pins done");
        wr(adcr_pkg::OFF_CTRL, 8'h1A);
        chk(O_CONV_CMD[11:9], 3'h6);
        rc(adcr_pkg::OFF_CTRL, 8'h1A);
        wr(adcr_pkg::OFF_CTRL, 8'h09);
        rc(adcr_pkg::OFF_CTRL, 8'h1A);
        wr(adcr_pkg::OFF_CTRL, 8'h1B);
        rc(adcr_pkg::OFF_CTRL, 8'h1A);
        wait_idle();
        chk(woke, 1'b0);
        rc(adcr_pkg::OFF_CTRL, 8'h0A);
        rc(adcr_pkg::OFF_RES_UP, 8'hAB);
        rc(adcr_pkg::OFF_RES_HN, 8'h0A);
        rc(adcr_pkg::OFF_RES_LO, 8'hB2);
        wr(adcr_pkg::OFF_INT_MSK, 8'h20);
        rc(adcr_pkg::OFF_INT_ST, 8'h20);
        wr(adcr_pkg::OFF_RES_UP, 8'h55);
        chk(bresp, adcr_pkg::RESP_OKAY);
        rc(adcr_pkg::OFF_RES_UP, 8'hAB);
        wr(adcr_pkg::OFF_CTRL, 8'h09);
        rc(adcr_pkg::OFF_CTRL, 8'h0A);
        wr(adcr_pkg::OFF_INT_ST, 8'h00);
        rc(adcr_pkg::OFF_INT_ST, 8'h00);
        wr(adcr_pkg::OFF_CTRL, 8'h09);
        chk(O_CONV_CMD.channel, 2'h1);
        wr(adcr_pkg::OFF_INT_ST, 8'h08);
        rc(adcr_pkg::OFF_INT_ST, 8'h08);
        I_SLEEPING <= 1'b1;
        wr(adcr_pkg::OFF_CTRL, 8'h39);
        wait_idle();
        chk(woke, 1'b1);
        rc(adcr_pkg::OFF_RES_LO, 8'hB1);
        rd(8'h24);
        chk(rresp, adcr_pkg::RESP_SLVERR);
        chk(rdat, 32'h0);
        wr(8'h24, 8'h01);
        chk(bresp, adcr_pkg::RESP_SLVERR);
        $display("test conversion done");
        print_verdict();
    end
endmodule
`default_nettype wire
